/* usb_line_pkg.sv */
package usb_line_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] line_ctrl_addr = 4'h0;
  localparam logic [3:0] err_ie_addr = 4'h1;
  localparam logic [3:0] err_flag_addr = 4'h2;
  localparam logic [3:0] irq_ctrl_addr = 4'h3;
  localparam logic [3:0] line_state_addr = 4'h4;

  // Line control field positions
  localparam int dp_pullup_pos = 7;
  localparam int dm_pullup_pos = 6;
  localparam int dp_pulldown_pos = 5;
  localparam int dm_pulldown_pos = 4;
  localparam int vbus_power_pos = 3;
  localparam int sw_sel_pos = 2;
  localparam int vbus_charge_pos = 1;
  localparam int vbus_discharge_pos = 0;

  // Error enable and flag positions
  localparam int bitstuff_pos = 7;
  localparam int matrix_pos = 6;
  localparam int dma_pos = 5;
  localparam int turnaround_pos = 4;
  localparam int field_size_pos = 3;
  localparam int crc16_pos = 2;
  localparam int crc5_eof_pos = 1;
  localparam int pid_pos = 0;

  // Module interrupt control fields
  localparam int error_summary_pos = 1;
  localparam int host_mode_pos = 0;
  localparam int irq_flag_pos = 8;

  // Reset values
  localparam logic [7:0] line_ctrl_rst = 8'h00;
  localparam logic [7:0] err_ie_rst = 8'h00;
  localparam logic [7:0] err_flag_rst = 8'h00;
  localparam logic [1:0] irq_ctrl_rst = 2'h0;

endpackage

/* usb_line_ctrl.sv */
`timescale 1ns/1ns
// How it works
// - Line control bit 7 enables the D+ pull-up.
// - Line control bit 6 enables the D- pull-up.
// - Line control bit 5 enables the D+ pull-down.
// - Line control bit 4 enables the D- pull-down.
// - Line control bit 3 powers VBUS.
// - Bit 2 set: software bits drive terminations; clear: USB hardware drives them.
// - Line control bit 1 charges VBUS through a pull-up.
// - Line control bit 0 discharges VBUS through a pull-down.
// - Bits 31 to 8 of both registers read zero, writes ignored.
// - Error enable bit 7 gates the bit-stuff error flag.
// - Error enable bit 6 gates the bus-matrix error flag.
// - Error enable bit 5 gates the DMA error flag.
// - Error enable bit 4 gates the turnaround time-out flag.
// - Error enable bit 3 gates the data field size flag.
// - Error enable bit 2 gates the CRC16 failure flag.
// - Error enable bit 1 gates CRC5 in device mode, end-of-frame in host mode.
// - Error enable bit 0 gates the PID check failure flag.
// - Errors reach the module flag only with the error summary enable set.
module usb_line_ctrl
  import usb_line_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic hw_dp_pullup,
  input wire logic hw_dm_pullup,
  input wire logic hw_dp_pulldown,
  input wire logic hw_dm_pulldown,
  input wire logic bitstuff_err_set,
  input wire logic matrix_err_set,
  input wire logic dma_err_set,
  input wire logic turnaround_timeout_set,
  input wire logic field_size_err_set,
  input wire logic crc16_fail_set,
  input wire logic crc5_fail_set,
  input wire logic frame_end_err_set,
  input wire logic pid_check_set,
  output logic dp_pullup_out,
  output logic dm_pullup_out,
  output logic dp_pulldown_out,
  output logic dm_pulldown_out,
  output logic vbus_power_out,
  output logic vbus_charge_out,
  output logic vbus_discharge_out,
  output logic error_irq_req,
  output logic module_irq_flag
);
  import usb_line_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] line_ctrl_q;
  logic [7:0] err_ie_q;
  logic [7:0] err_flag_q;
  logic [7:0] err_flag_d;
  logic [1:0] irq_ctrl_q;
  logic module_irq_flag_q;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic line_ctrl_wr;
  logic err_ie_wr;
  logic err_flag_wr;
  logic irq_ctrl_wr;
  logic host_mode;
  logic error_pending;
  logic [7:0] term_now;
  logic [31:0] rdata_d;

  assign line_ctrl_wr = reg_wr && (reg_addr == line_ctrl_addr);
  assign err_ie_wr = reg_wr && (reg_addr == err_ie_addr);
  assign err_flag_wr = reg_wr && (reg_addr == err_flag_addr);
  assign irq_ctrl_wr = reg_wr && (reg_addr == irq_ctrl_addr);
  assign host_mode = irq_ctrl_q[host_mode_pos];

  ////////////////////////////////////////////////////////////////////////////
  // Line control register, low byte only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_ctrl_q <= line_ctrl_rst;
    end else if (line_ctrl_wr) begin
      line_ctrl_q <= reg_wdata[7:0];
    end
  end

  // Error enable register, low byte only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      err_ie_q <= err_ie_rst;
    end else if (err_ie_wr) begin
      err_ie_q <= reg_wdata[7:0];
    end
  end

  // Module interrupt control: error summary enable and host mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_ctrl_q <= irq_ctrl_rst;
    end else if (irq_ctrl_wr) begin
      irq_ctrl_q <= reg_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error event sources, bit 1 chosen by mode
  always_comb begin
    err_set = 8'h00;
    err_set[bitstuff_pos] = bitstuff_err_set;
    err_set[matrix_pos] = matrix_err_set;
    err_set[dma_pos] = dma_err_set;
    err_set[turnaround_pos] = turnaround_timeout_set;
    err_set[field_size_pos] = field_size_err_set;
    err_set[crc16_pos] = crc16_fail_set;
    err_set[crc5_eof_pos] = host_mode ? frame_end_err_set : crc5_fail_set;
    err_set[pid_pos] = pid_check_set;
  end

  // Sticky flags, write one to clear, a new event beats the clear
  assign err_clr = err_flag_wr ? reg_wdata[7:0] : 8'h00;
  assign err_flag_d = (err_flag_q & ~err_clr) | err_set;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      err_flag_q <= err_flag_rst;
    end else begin
      err_flag_q <= err_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error request: each flag gated by its enable
  assign error_pending = |(err_flag_q & err_ie_q);
  // Same gating covers field size, CRC16, CRC5/EOF and PID

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      error_irq_req <= 1'b0;
    end else begin
      error_irq_req <= error_pending;
    end
  end

  // Module flag needs the error summary enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      module_irq_flag_q <= 1'b0;
    end else begin
      module_irq_flag_q <= error_pending && irq_ctrl_q[error_summary_pos];
    end
  end
  assign module_irq_flag = module_irq_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Termination source select
  always_comb begin
    term_now = 8'h00;
    if (line_ctrl_q[sw_sel_pos]) begin
      term_now[dp_pullup_pos] = line_ctrl_q[dp_pullup_pos];
      term_now[dm_pullup_pos] = line_ctrl_q[dm_pullup_pos];
      term_now[dp_pulldown_pos] = line_ctrl_q[dp_pulldown_pos];
      term_now[dm_pulldown_pos] = line_ctrl_q[dm_pulldown_pos];
    end else begin
      term_now[dp_pullup_pos] = hw_dp_pullup;
      term_now[dm_pullup_pos] = hw_dm_pullup;
      term_now[dp_pulldown_pos] = hw_dp_pulldown;
      term_now[dm_pulldown_pos] = hw_dm_pulldown;
    end
  end

  // Registered line outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dp_pullup_out <= 1'b0;
      dm_pullup_out <= 1'b0;
      dp_pulldown_out <= 1'b0;
      dm_pulldown_out <= 1'b0;
      vbus_power_out <= 1'b0;
      vbus_charge_out <= 1'b0;
      vbus_discharge_out <= 1'b0;
    end else begin
      dp_pullup_out <= term_now[dp_pullup_pos];
      dm_pullup_out <= term_now[dm_pullup_pos];
      dp_pulldown_out <= term_now[dp_pulldown_pos];
      dm_pulldown_out <= term_now[dm_pulldown_pos];
      vbus_power_out <= line_ctrl_q[vbus_power_pos];
      vbus_charge_out <= line_ctrl_q[vbus_charge_pos];
      vbus_discharge_out <= line_ctrl_q[vbus_discharge_pos];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, bits 31 to 9 zero, bit 8 carries the module flag on interrupt control reads
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (reg_addr)
      line_ctrl_addr: rdata_d[7:0] = line_ctrl_q;
      err_ie_addr: rdata_d[7:0] = err_ie_q;
      err_flag_addr: rdata_d[7:0] = err_flag_q;
      irq_ctrl_addr: begin
        rdata_d[1:0] = irq_ctrl_q;
        rdata_d[irq_flag_pos] = module_irq_flag_q;
      end
      line_state_addr: begin
        rdata_d[7:0] = term_now;
        rdata_d[vbus_power_pos] = line_ctrl_q[vbus_power_pos];
        rdata_d[vbus_charge_pos] = line_ctrl_q[vbus_charge_pos];
        rdata_d[vbus_discharge_pos] = line_ctrl_q[vbus_discharge_pos];
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // usb_line_ctrl

/* usb_line_ctrl_monitor.sv */
`timescale 1ns/1ns
module usb_line_ctrl_monitor
  import usb_line_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic dp_pullup_out,
  input wire logic dm_pullup_out,
  input wire logic dp_pulldown_out,
  input wire logic dm_pulldown_out,
  input wire logic vbus_power_out,
  input wire logic vbus_charge_out,
  input wire logic vbus_discharge_out,
  input wire logic error_irq_req,
  input wire logic module_irq_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Line outputs two cycles after a lone line write
  chk_term_sw: assert property (
    reg_wr && reg_addr == line_ctrl_addr && reg_wdata[2] ##1 !reg_wr |=>
    {dp_pullup_out, dm_pullup_out, dp_pulldown_out, dm_pulldown_out} == $past(reg_wdata[7:4], 2))
    else $error("bad terminations");
  chk_vbus_ctl: assert property (
    reg_wr && reg_addr == line_ctrl_addr ##1 !reg_wr |=>
    {vbus_power_out, vbus_charge_out, vbus_discharge_out} == $past({reg_wdata[3], reg_wdata[1:0]}, 2))
    else $error("bad vbus controls");
  // Read data shape
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("stale read data");
  chk_rd_high: assert property (reg_rd |=> reg_rdata[31:9] == 23'h0)
    else $error("upper read bits set");
  chk_rd_unmapped: assert property (reg_rd && reg_addr > line_state_addr |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  // Error request gating
  chk_ie_off: assert property (
    reg_wr && reg_addr == err_ie_addr && reg_wdata[7:0] == 8'h00 |-> ##2 !error_irq_req)
    else $error("request with enables clear");
  chk_flag_req: assert property (module_irq_flag |-> error_irq_req)
    else $error("module flag without request");
  chk_summary_off: assert property (
    reg_wr && reg_addr == irq_ctrl_addr && !reg_wdata[error_summary_pos] |-> ##2 !module_irq_flag)
    else $error("module flag with summary off");
endmodule // usb_line_ctrl_monitor

bind usb_line_ctrl usb_line_ctrl_monitor mon (.*);

/* usb_bus_line.sv */
`timescale 1ns/1ns
module usb_bus_line (
  input wire logic clk,
  input wire logic pull_up,
  input wire logic pull_down,
  output logic level
);
  // Pull-up wins, then pull-down; an open line wanders
  always_ff @(posedge clk) begin
    level <= pull_up ? 1'b1 : (pull_down ? 1'b0 : level !== 1'b1);
  end
endmodule // usb_bus_line

/* tb_usb_line_ctrl.sv */
`timescale 1ns/1ns
module tb_usb_line_ctrl;
  import usb_line_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pend = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [3:0] hw = 4'h0;
  logic [8:0] ev = 9'h0;
  logic [31:0] reg_rdata;
  logic [31:0] v;
  logic [31:0] exp_q[$];
  logic [6:0] pins;
  logic [3:0] t;
  logic [2:0] b;
  logic [1:0] irq;
  logic [1:0] lvl;
  int errors = 0;
  int n_compared = 0;
  int seed = 32'hc8d9;
  usb_line_ctrl dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hw_dp_pullup(hw[3]),
    .hw_dm_pullup(hw[2]), .hw_dp_pulldown(hw[1]), .hw_dm_pulldown(hw[0]), .bitstuff_err_set(ev[7]),
    .matrix_err_set(ev[6]), .dma_err_set(ev[5]), .turnaround_timeout_set(ev[4]), .field_size_err_set(ev[3]),
    .crc16_fail_set(ev[2]), .crc5_fail_set(ev[1]), .frame_end_err_set(ev[8]), .pid_check_set(ev[0]),
    .dp_pullup_out(pins[6]), .dm_pullup_out(pins[5]), .dp_pulldown_out(pins[4]), .dm_pulldown_out(pins[3]),
    .vbus_power_out(pins[2]), .vbus_charge_out(pins[1]), .vbus_discharge_out(pins[0]),
    .error_irq_req(irq[1]), .module_irq_flag(irq[0]));
  usb_bus_line dp_line (.clk, .pull_up(pins[6]), .pull_down(pins[4]), .level(lvl[1]));
  usb_bus_line dm_line (.clk, .pull_up(pins[5]), .pull_down(pins[3]), .level(lvl[0]));
  // Clock and hang guard
  initial forever #25 clk = ~clk;
  initial begin
    #100000;
    errors++;
    end_sim;
  end
  task cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  // Op 2'b10 write, 2'b01 read noting the answer, 2'b00 idle
  task bus(input logic [1:0] op, input logic [3:0] a, input logic [31:0] d);
    if (op[0]) exp_q.push_back(d);
    {reg_wr, reg_rd} <= op;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task idle(input int n);
    repeat (n) bus(2'b00, 4'h0, 32'h0);
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Answers checked against the oldest note
  always @(posedge clk) begin
    if (pend) cmp("read data", exp_q.pop_front(), reg_rdata);
    pend <= reg_rd;
  end
  // Reset, random line settings, then each error source
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    bus(2'b01, line_ctrl_addr, 32'h0);
    bus(2'b01, 4'hf, 32'h0);
    repeat (8) begin
      v = $random(seed);
      t = v[2] ? v[7:4] : v[11:8];
      hw <= v[11:8];
      bus(2'b10, line_ctrl_addr, v);
      bus(2'b01, line_ctrl_addr, {24'h0, v[7:0]});
      bus(2'b10, err_ie_addr, ~v);
      bus(2'b01, err_ie_addr, {24'h0, ~v[7:0]});
      bus(2'b01, line_state_addr, {24'h0, t, v[3], 1'b0, v[1:0]});
      cmp("pins", {t, v[3], v[1:0]}, pins);
      if (t[3] | t[1]) cmp("dp line", t[3], lvl[1]);
    end
    bus(2'b10, err_ie_addr, 32'h0);
    for (int j = 0; j < 9; j++) begin
      b = (j == 8) ? 3'h1 : j[2:0];
      bus(2'b10, irq_ctrl_addr, {30'h0, j[0], j == 8});
      bus(2'b10, err_ie_addr, ~(32'h1 << b));
      ev <= 9'h1 << j;
      idle(1);
      ev <= 9'h0;
      idle(3);
      cmp("masked", 32'h0, irq);
      bus(2'b10, err_ie_addr, 32'h1 << b);
      idle(3);
      cmp("enabled", {1'b1, j[0]}, irq);
      bus(2'b01, err_flag_addr, 32'h1 << b);
      bus(2'b01, irq_ctrl_addr, {23'h0, j[0], 6'h0, j[0], j == 8});
      bus(2'b10, err_flag_addr, 32'hff);
      idle(3);
      cmp("cleared", 32'h0, irq);
    end
    end_sim;
  end
endmodule // tb_usb_line_ctrl
